// >>> cantwk_pkg.sv
// Shared constants, modes and record types of the CAN transceiver wake and drive logic.
package cantwk_pkg;

  // Sampling clock.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Activity filter time: a longest time, so the cycle count rounds down.
  localparam int unsigned ACTIVITY_FILTER_TIME_NS = 3600;
  localparam int unsigned FILTER_CYC = (ACTIVITY_FILTER_TIME_NS / CLK_PERIOD_NS < 1) ? 1 :
                                       ACTIVITY_FILTER_TIME_NS / CLK_PERIOD_NS;

  // Wake pattern timeout window, measured from the first dominant sample.
  localparam int unsigned WAKE_PATTERN_TIMEOUT_US = 1000;
  localparam int unsigned WAKE_TO_CYC = WAKE_PATTERN_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // Longest permitted dominant request on transmit data before the drivers are cut.
  localparam int unsigned TXD_DOM_TIMEOUT_US = 1000;
  localparam int unsigned TXD_TO_CYC = TXD_DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  // Receive record buffer depth.
  localparam int unsigned RX_FIFO_DEPTH = 8;

  // Values after reset of the pin-facing outputs.
  localparam logic RXD_RESET = 1'h1;
  localparam logic DRIVE_RESET = 1'h0;

  typedef enum logic [1:0] {
    MODE_WAKE    = 2'h0,
    MODE_NORMAL  = 2'h1,
    MODE_STANDBY = 2'h3
  } cantwk_mode_e;

  typedef enum logic [1:0] {
    WK_IDLE = 2'h0,
    WK_DOM1 = 2'h1,
    WK_REC  = 2'h3,
    WK_DOM2 = 2'h2
  } cantwk_wk_e;

  typedef enum logic {
    WAKE_BASIC   = 1'h0,
    WAKE_PATTERN = 1'h1
  } cantwk_wkvar_e;

  // One bus transition seen in normal operation.
  typedef struct packed {
    logic dominant;
    logic own_drive;
  } cantwk_rxrec_s;

  localparam int unsigned RXREC_W = $bits(cantwk_rxrec_s);

endpackage

// >>> cantwk_sync.sv
// Two-stage synchronizer for asynchronous level inputs.
`timescale 1ns/100ps
module cantwk_sync #(
  parameter int unsigned W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] din_i,
  output logic [W-1:0] dout_o
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage1_d;
  logic [W-1:0] stage2_d;

  always_comb begin
    stage1_d = din_i;
    stage2_d = stage1_q;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  assign dout_o = stage2_q;

  chk_sync_two_stage: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!$past(rst_i) && !$past(rst_i, 2)) |-> (dout_o == $past(din_i, 2)))
    else $error("synchronizer output is not the input two cycles back");

endmodule // cantwk_sync

// >>> cantwk_fifo.sv
// Parameterised FIFO with valid/ready on both sides and a registered output stage.
`timescale 1ns/100ps
module cantwk_fifo #(
  parameter int unsigned W = 2,
  parameter int unsigned DEPTH = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic oval_q, oval_d;
  logic [W-1:0] odat_q, odat_d;
  logic push, pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_comb begin
    push = in_valid_i && (cnt_q != CW'(DEPTH));
    pop = (cnt_q != '0) && (!oval_q || out_ready_i);
    mem_d = mem_q;
    wptr_d = wptr_q;
    rptr_d = rptr_q;
    cnt_d = cnt_q;
    oval_d = oval_q;
    odat_d = odat_q;
    if (push) begin
      mem_d[wptr_q] = in_data_i;
      wptr_d = ptr_inc(wptr_q);
    end
    if (pop) begin
      odat_d = mem_q[rptr_q];
      rptr_d = ptr_inc(rptr_q);
      oval_d = 1'b1;
    end else if (out_ready_i) begin
      oval_d = 1'b0;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + CW'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          mem_q[i] <= '0;
        end else begin
          mem_q[i] <= mem_d[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
      oval_q <= 1'b0;
      odat_q <= '0;
    end else begin
      wptr_q <= wptr_d;
      rptr_q <= rptr_d;
      cnt_q <= cnt_d;
      oval_q <= oval_d;
      odat_q <= odat_d;
    end
  end

  assign in_ready_o = (cnt_q != CW'(DEPTH));
  assign out_valid_o = oval_q;
  assign out_data_o = odat_q;

endmodule // cantwk_fifo

// >>> cantwk_top.sv
// Mode control, bus drive, receive output and wake detection of a CAN transceiver.
`timescale 1ns/100ps

module cantwk_top
  import cantwk_pkg::*;
#(
  parameter cantwk_wkvar_e WAKE_VARIANT = WAKE_PATTERN,
  parameter int unsigned FILTER_CYCLES = FILTER_CYC,
  parameter int unsigned WAKE_TO_CYCLES = WAKE_TO_CYC,
  parameter int unsigned TXD_TO_CYCLES = TXD_TO_CYC,
  parameter int unsigned FIFO_DEPTH = RX_FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic txd_i,
  input wire logic standby_select_i,
  input wire logic bus_dominant_i,
  input wire logic over_temp_i,
  output logic drive_dominant_o,
  output logic rxd_o,
  output logic wake_o,
  output logic [1:0] mode_o,
  output logic rxs_valid_o,
  input wire logic rxs_ready_i,
  output cantwk_rxrec_s rxs_data_o,
  output logic rxs_overrun_o
);

  localparam int unsigned FW = $clog2(FILTER_CYCLES + 1);
  localparam int unsigned TW = $clog2(WAKE_TO_CYCLES + 1);
  localparam int unsigned XW = $clog2(TXD_TO_CYCLES + 1);
  localparam logic [FW-1:0] FILT = FW'(FILTER_CYCLES);
  localparam logic [FW-1:0] FILT_M1 = FW'(FILTER_CYCLES - 1);
  localparam logic [TW-1:0] WTO_M1 = TW'(WAKE_TO_CYCLES - 1);
  localparam logic [XW-1:0] XTO_M1 = XW'(TXD_TO_CYCLES - 1);

  cantwk_mode_e mode_q, mode_d;
  cantwk_wk_e wk_q, wk_d;
  logic [FW-1:0] ph_q, ph_d;
  logic [TW-1:0] tmr_q, tmr_d;
  logic wake_q, wake_d;
  logic [XW-1:0] xcnt_q, xcnt_d;
  logic lock_q, lock_d;
  logic drive_q, drive_d;
  logic rxd_q, rxd_d;
  logic prev_q, prev_d;
  logic pend_q, pend_d;
  logic ovr_q, ovr_d;
  cantwk_rxrec_s rec_q, rec_d;
  logic bus_sync;
  logic bus_dom;
  logic fifo_in_ready;
  logic [FW-1:0] ph_inc;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // bus state synchronizer
  cantwk_sync #(
    .W(1)
  ) u_bus_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .din_i(bus_dominant_i),
    .dout_o(bus_sync)
  );

  assign bus_dom = bus_sync | drive_q;
  assign ph_inc = (ph_q == FILT) ? ph_q : ph_q + FW'(1);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Mode control.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_WAKE: begin
        if (standby_select_i) begin
          mode_d = MODE_STANDBY;
        end else if (txd_i) begin
          mode_d = MODE_NORMAL;
        end
      end
      MODE_NORMAL: begin
        if (standby_select_i) begin
          mode_d = MODE_STANDBY;
        end
      end
      MODE_STANDBY: begin
        if (!standby_select_i) begin
          mode_d = MODE_WAKE;
        end
      end
      default: mode_d = MODE_WAKE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Wake detection, active only in standby.
  always_comb begin
    wk_d = wk_q;
    ph_d = ph_q;
    tmr_d = tmr_q;
    wake_d = wake_q;
    if (mode_q != MODE_STANDBY) begin
      wk_d = WK_IDLE;
      ph_d = '0;
      tmr_d = '0;
      wake_d = 1'b0;
    end else if (wake_q) begin
      wk_d = WK_IDLE;
      ph_d = '0;
      tmr_d = '0;
    end else if (WAKE_VARIANT == WAKE_PATTERN && wk_q != WK_IDLE && tmr_q >= WTO_M1) begin
      wk_d = WK_IDLE;
      ph_d = '0;
      tmr_d = '0;
    end else begin
      if (wk_q != WK_IDLE) begin
        tmr_d = tmr_q + TW'(1);
      end
      case (wk_q)
        WK_IDLE: begin
          if (bus_dom) begin
            wk_d = WK_DOM1;
            ph_d = FW'(1);
            tmr_d = TW'(1);
          end
        end
        WK_DOM1: begin
          if (bus_dom) begin
            ph_d = ph_inc;
            if (WAKE_VARIANT == WAKE_BASIC && ph_q >= FILT_M1) begin
              wake_d = 1'b1;
            end
          end else if (WAKE_VARIANT == WAKE_PATTERN && ph_q >= FILT) begin
            wk_d = WK_REC;
            ph_d = FW'(1);
          end else begin
            wk_d = WK_IDLE;
            ph_d = '0;
            tmr_d = '0;
          end
        end
        WK_REC: begin
          if (!bus_dom) begin
            ph_d = ph_inc;
          end else if (ph_q >= FILT) begin
            wk_d = WK_DOM2;
            ph_d = FW'(1);
          end else begin
            // A short recessive gap is ignored; the first phase stays qualified.
            wk_d = WK_DOM1;
            ph_d = FILT;
          end
        end
        WK_DOM2: begin
          if (bus_dom) begin
            ph_d = ph_inc;
            if (ph_q >= FILT_M1) begin
              wake_d = 1'b1;
            end
          end else begin
            wk_d = WK_REC;
            ph_d = FW'(1);
          end
        end
        default: begin
          wk_d = WK_IDLE;
          ph_d = '0;
          tmr_d = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Transmit path and receive output.
  always_comb begin
    xcnt_d = '0;
    lock_d = 1'b0;
    if (mode_q == MODE_NORMAL && !txd_i) begin
      lock_d = lock_q || (xcnt_q >= XTO_M1);
      xcnt_d = lock_d ? xcnt_q : xcnt_q + XW'(1);
    end
    drive_d = (mode_q == MODE_NORMAL) && !txd_i && !lock_q && !over_temp_i;
    case (mode_q)
      MODE_NORMAL: rxd_d = !bus_dom;
      MODE_STANDBY: rxd_d = !wake_q;
      default: rxd_d = RXD_RESET;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus transition records; a record waits in rec_q, flagged by pend_q, while the buffer is full.
  always_comb begin
    prev_d = bus_dom;
    rec_d = rec_q;
    pend_d = pend_q && !fifo_in_ready;
    ovr_d = ovr_q;
    if (mode_q != MODE_NORMAL) begin
      pend_d = 1'b0;
      ovr_d = 1'b0;
    end else if (bus_dom != prev_q) begin
      rec_d.dominant = bus_dom;
      rec_d.own_drive = drive_q;
      pend_d = 1'b1;
      if (pend_q && !fifo_in_ready) begin
        ovr_d = 1'b1;
      end
    end
  end

  cantwk_fifo #(
    .W(RXREC_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .in_valid_i(pend_q),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rec_q),
    .out_valid_o(rxs_valid_o),
    .out_ready_i(rxs_ready_i),
    .out_data_o(rxs_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_q <= MODE_WAKE;
      wk_q <= WK_IDLE;
      ph_q <= '0;
      tmr_q <= '0;
      wake_q <= 1'b0;
      xcnt_q <= '0;
      lock_q <= 1'b0;
      drive_q <= DRIVE_RESET;
      rxd_q <= RXD_RESET;
      prev_q <= 1'b0;
      pend_q <= 1'b0;
      ovr_q <= 1'b0;
      rec_q <= '0;
    end else begin
      mode_q <= mode_d;
      wk_q <= wk_d;
      ph_q <= ph_d;
      tmr_q <= tmr_d;
      wake_q <= wake_d;
      xcnt_q <= xcnt_d;
      lock_q <= lock_d;
      drive_q <= drive_d;
      rxd_q <= rxd_d;
      prev_q <= prev_d;
      pend_q <= pend_d;
      ovr_q <= ovr_d;
      rec_q <= rec_d;
    end
  end

  assign drive_dominant_o = drive_q;
  assign rxd_o = rxd_q;
  assign wake_o = wake_q;
  assign mode_o = mode_q;
  assign rxs_overrun_o = ovr_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_wake_rise;
    $rose(wake_q) && (mode_q == MODE_STANDBY);
  endsequence

  sequence s_dom1_to_rec;
    (wk_q == WK_DOM1) ##1 (wk_q == WK_REC);
  endsequence

  chk_basic_wake_time: assert property (
    ((WAKE_VARIANT == WAKE_BASIC) and s_wake_rise) |-> $past(ph_q) >= FILT_M1)
    else $error("basic wake raised before the filter time");

  chk_pattern_order: assert property (
    ((WAKE_VARIANT == WAKE_PATTERN) and s_wake_rise) |-> $past(wk_q) == WK_DOM2)
    else $error("pattern wake raised outside the second dominant phase");

  chk_phase_length: assert property (
    s_dom1_to_rec |-> $past(ph_q) >= FILT)
    else $error("short first dominant phase advanced the pattern");

  chk_window_bound: assert property (
    ((WAKE_VARIANT == WAKE_PATTERN) and s_wake_rise) |-> $past(tmr_q) < WTO_M1)
    else $error("pattern accepted after the timeout window");

  chk_drive_request: assert property (
    drive_dominant_o |-> !$past(txd_i) && $past(mode_q) == MODE_NORMAL)
    else $error("dominant drive without a dominant request in normal mode");

  chk_wired_bus: assert property (
    (bus_sync || drive_q) |-> bus_dom)
    else $error("dominant source did not make the bus dominant");

  chk_rxd_normal: assert property (
    (mode_q == MODE_NORMAL) |=> (rxd_o == !$past(bus_dom)))
    else $error("receive output does not follow the bus in normal mode");

  chk_overtemp_off: assert property (
    over_temp_i |=> !drive_dominant_o)
    else $error("drivers stayed on under over-temperature");

  chk_overtemp_mode: assert property (
    (mode_q == MODE_NORMAL) && !txd_i && !lock_q && !over_temp_i |=> drive_dominant_o)
    else $error("drivers off in normal mode without cause");

  chk_txd_lock: assert property (
    (mode_q == MODE_NORMAL) && lock_q && !txd_i |=> !drive_dominant_o && lock_q)
    else $error("transmit lock released or drivers on while transmit low");

  chk_standby_high: assert property (
    (mode_q == MODE_STANDBY) && !wake_q |=> rxd_o)
    else $error("receive output low in standby before wake");

  chk_wake_edge: assert property (
    s_wake_rise |=> !rxd_o)
    else $error("wake not shown by a low receive output");

  chk_timeout_reset: assert property (
    (WAKE_VARIANT == WAKE_PATTERN) && (mode_q == MODE_STANDBY) && !wake_q &&
    (wk_q != WK_IDLE) && (tmr_q >= WTO_M1) |=> (wk_q == WK_IDLE) && !wake_q)
    else $error("pattern detector not reset at timeout");

endmodule // cantwk_top

// >>> cantwk_ctrl_model.sv
// Controller-side model: drives transmit and standby, consumes receive records.
`timescale 1ns/100ps
module cantwk_ctrl_model
  import cantwk_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic send_dom_i,
  input wire logic sleep_req_i,
  input wire logic stall_i,
  input wire logic rxd_i,
  input wire logic rxs_valid_i,
  input wire cantwk_rxrec_s rxs_data_i,
  output logic txd_o,
  output logic standby_select_o,
  output logic rxs_ready_o,
  output cantwk_rxrec_s last_rec_o,
  output logic [7:0] rec_count_o
);
  logic woke_q;
  logic wake_seen;

  assign wake_seen = standby_select_o & ~rxd_i;

  // A controller that is still powering up pulls transmit low, so it resets low.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      txd_o <= 1'h0;
      standby_select_o <= 1'h0;
      rxs_ready_o <= 1'h0;
      woke_q <= 1'h0;
      last_rec_o <= '0;
      rec_count_o <= 8'h00;
    end else begin
      txd_o <= ~send_dom_i;
      woke_q <= sleep_req_i & (woke_q | wake_seen);
      standby_select_o <= sleep_req_i & ~woke_q & ~wake_seen;
      rxs_ready_o <= ~stall_i;
      if (rxs_valid_i && rxs_ready_o) begin
        last_rec_o <= rxs_data_i;
        rec_count_o <= rec_count_o + 8'h01;
      end
    end
  end
endmodule // cantwk_ctrl_model

// >>> cantwk_top_bench.sv
// Self-checking bench for the CAN transceiver wake and drive logic.
`timescale 1ns/100ps
module cantwk_top_bench;
  import cantwk_pkg::*;

  logic mclk_i = 1'h0;
  logic rst_i, bus_dominant_i, over_temp_i, send_dom, sleep_req, stall, rxd_fell, rxd_b;
  logic txd, standby_select_sel, rxs_ready, drive_dominant, rxd, wake, rxs_valid, rxs_overrun, wake_b;
  logic [1:0] mode;
  logic [7:0] rec_count;
  cantwk_rxrec_s rxs_data, last_rec;
  int n_fail = 0;
  int cmp_count = 0;

  always #5 mclk_i = ~mclk_i;

  cantwk_top #(.FILTER_CYCLES(4), .WAKE_TO_CYCLES(64), .TXD_TO_CYCLES(20)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .txd_i(txd), .standby_select_i(standby_select_sel),
    .bus_dominant_i(bus_dominant_i), .over_temp_i(over_temp_i),
    .drive_dominant_o(drive_dominant), .rxd_o(rxd), .wake_o(wake), .mode_o(mode),
    .rxs_valid_o(rxs_valid), .rxs_ready_i(rxs_ready), .rxs_data_o(rxs_data),
    .rxs_overrun_o(rxs_overrun));

  // Basic-variant twin that sees the same inputs.
  cantwk_top #(.WAKE_VARIANT(WAKE_BASIC), .FILTER_CYCLES(4), .WAKE_TO_CYCLES(64),
    .TXD_TO_CYCLES(20)) dut_b (
    .mclk_i(mclk_i), .rst_i(rst_i), .txd_i(txd), .standby_select_i(standby_select_sel),
    .bus_dominant_i(bus_dominant_i), .over_temp_i(over_temp_i), .drive_dominant_o(),
    .rxd_o(rxd_b), .wake_o(wake_b), .mode_o(), .rxs_valid_o(), .rxs_ready_i(rxs_ready),
    .rxs_data_o(), .rxs_overrun_o());

  cantwk_ctrl_model ctrl (
    .mclk_i(mclk_i), .rst_i(rst_i), .send_dom_i(send_dom), .sleep_req_i(sleep_req),
    .stall_i(stall), .rxd_i(rxd), .rxs_valid_i(rxs_valid), .rxs_data_i(rxs_data),
    .txd_o(txd), .standby_select_o(standby_select_sel), .rxs_ready_o(rxs_ready),
    .last_rec_o(last_rec), .rec_count_o(rec_count));

  // Remembers a low receive level seen in standby until sleep is withdrawn.
  always @(posedge mclk_i) begin
    if (!sleep_req)
      rxd_fell <= 1'h0;
    else if (mode == MODE_STANDBY && rxd === 1'h0)
      rxd_fell <= 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic bus(input logic v, input int n);
    @(posedge mclk_i);
    bus_dominant_i <= v;
    repeat (n - 1) @(posedge mclk_i);
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    cyc(1);
    chk("drive", 8'h00, drive_dominant);
    chk("rxd", 8'h01, rxd);
    chk("wake", 8'h00, wake);
    chk("mode", MODE_WAKE, mode);
    cyc(6);
    chk("mode txd low", MODE_WAKE, mode);
    @(posedge mclk_i);
    send_dom <= 1'h0;
    cyc(3);
    chk("mode txd high", MODE_NORMAL, mode);
  endtask

  task automatic t_txrx;
    @(posedge mclk_i);
    send_dom <= 1'h1;
    cyc(4);
    chk("drive", 8'h01, drive_dominant);
    chk("rxd own", 8'h00, rxd);
    cyc(6);
    chk("record own", 8'h03, last_rec);
    @(posedge mclk_i);
    send_dom <= 1'h0;
    cyc(8);
    chk("drive off", 8'h00, drive_dominant);
    chk("rxd rec", 8'h01, rxd);
    chk("record rec", 8'h00, last_rec);
    bus(1'h1, 10);
    #1;
    chk("rxd other", 8'h00, rxd);
    chk("record other", 8'h02, last_rec);
  endtask

  task automatic t_overtemp;
    @(posedge mclk_i);
    over_temp_i <= 1'h1;
    send_dom <= 1'h1;
    cyc(4);
    chk("drive hot", 8'h00, drive_dominant);
    chk("rxd hot", 8'h00, rxd);
    @(posedge mclk_i);
    over_temp_i <= 1'h0;
    cyc(3);
    chk("drive cool", 8'h01, drive_dominant);
    @(posedge mclk_i);
    send_dom <= 1'h0;
    bus_dominant_i <= 1'h0;
    cyc(6);
  endtask

  task automatic t_txd_lock;
    @(posedge mclk_i);
    send_dom <= 1'h1;
    cyc(10);
    chk("drive held", 8'h01, drive_dominant);
    cyc(20);
    chk("drive locked", 8'h00, drive_dominant);
    bus(1'h1, 6);
    #1;
    chk("rxd locked", 8'h00, rxd);
    bus(1'h0, 1);
    send_dom <= 1'h0;
    cyc(3);
    @(posedge mclk_i);
    send_dom <= 1'h1;
    cyc(4);
    chk("drive unlocked", 8'h01, drive_dominant);
    @(posedge mclk_i);
    send_dom <= 1'h0;
    cyc(6);
  endtask

  task automatic t_wake;
    @(posedge mclk_i);
    sleep_req <= 1'h1;
    cyc(4);
    chk("mode standby", MODE_STANDBY, mode);
    bus(1'h1, 2);
    bus(1'h0, 10);
    #1;
    chk("rxd standby", 8'h01, rxd);
    chk("wake short", 8'h00, wake);
    chk("basic short", 8'h00, wake_b);
    bus(1'h1, 8);
    #1;
    chk("basic wake", 8'h01, wake_b);
    chk("basic rxd", 8'h00, rxd_b);
    chk("wake one phase", 8'h00, wake);
    bus(1'h0, 6);
    #1;
    chk("wake two phases", 8'h00, wake);
    bus(1'h1, 8);
    #1;
    chk("wake pattern", 8'h01, wake);
    cyc(6);
    chk("rxd fell", 8'h01, rxd_fell);
    chk("mode back", MODE_NORMAL, mode);
  endtask

  task automatic t_timeout;
    @(posedge mclk_i);
    sleep_req <= 1'h0;
    bus_dominant_i <= 1'h0;
    cyc(2);
    @(posedge mclk_i);
    sleep_req <= 1'h1;
    cyc(4);
    bus(1'h1, 8);
    bus(1'h0, 70);
    bus(1'h1, 8);
    #1;
    chk("wake late", 8'h00, wake);
    bus(1'h0, 6);
    bus(1'h1, 8);
    #1;
    chk("wake restart", 8'h01, wake);
    bus(1'h0, 6);
    sleep_req <= 1'h0;
    cyc(6);
    chk("mode normal", MODE_NORMAL, mode);
  endtask

  task automatic t_fifo;
    logic [7:0] n0;
    n0 = rec_count;
    @(posedge mclk_i);
    stall <= 1'h1;
    for (int i = 0; i < 24; i++)
      bus(~bus_dominant_i, 6);
    #1;
    chk("fifo valid", 8'h01, rxs_valid);
    chk("overrun", 8'h01, rxs_overrun);
    @(posedge mclk_i);
    stall <= 1'h0;
    cyc(40);
    chk("fifo drained", 8'h00, rxs_valid);
    chk("drained count", 8'h0A, rec_count - n0);
    chk("newest kept", 8'h00, last_rec);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    $display("CHECK FAILED watchdog expected finish seen hang");
    close_out;
  end

  initial begin
    rst_i = 1'h1;
    bus_dominant_i = 1'h0;
    over_temp_i = 1'h0;
    send_dom = 1'h1;
    sleep_req = 1'h0;
    stall = 1'h0;
    rxd_fell = 1'h0;
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'h0;
    t_reset;
    t_txrx;
    t_overtemp;
    t_txd_lock;
    t_wake;
    t_timeout;
    t_fifo;
    close_out;
  end
endmodule // cantwk_top_bench
